// >>> hw/wdt_pkg.sv
// package: constants, types and field layout of the watchdog block
package wdt_pkg;
  localparam logic [3:0] WDT_CFG_GP = 4'hf;
  localparam logic [3:0] WDT_CFG_STOP_LP = 4'h5;
  localparam int WDT_BIT_RUN = 7;
  localparam int WDT_BIT_CLR = 6;
  localparam int WDT_BIT_TOF = 5;
  localparam int WDT_BIT_LPR = 4;
  localparam int WDT_BIT_RCF = 3;
  localparam int WDT_PS_MSB = 2;
  localparam logic [2:0] WDT_PS_POR = 3'h7;
  localparam logic [7:0] WDT_TA_KEY1 = 8'haa;
  localparam logic [7:0] WDT_TA_KEY2 = 8'h55;
  localparam int WDT_INTERVAL_TICKS = 64;
  localparam int WDT_GRACE_TICKS = 512;
  localparam int WDT_PRE_W = 8;
  localparam int WDT_CNT_W = 6;
  localparam int WDT_GRC_W = 10;
  localparam int WDT_OSC_HZ = 10000;
  localparam int WDT_SYS_HZ = 40000000;
  localparam int WDT_OSC_DIV = WDT_SYS_HZ / WDT_OSC_HZ;

  typedef struct packed {
    logic [7:0] data;
    logic ta_we;
    logic ctl_we;
  } wdt_wr_t;

  typedef struct packed {
    logic run;
    logic lpr;
    logic [2:0] ps;
  } wdt_cfg_t;
endpackage

// >>> hw/wdt_sync.sv
// module: two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module wdt_sync
  import wdt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule
`default_nettype wire

// >>> hw/wdt_tick.sv
// module: low-speed oscillator tick; divides the system clock to 10 kHz
`timescale 1ns/1ps
`default_nettype none
module wdt_tick
  import wdt_pkg::*;
#(
  parameter int DIV = WDT_OSC_DIV
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  output logic o_tick
);
  logic [15:0] cnt_q;
  logic tick_q;
  wire wrap = (cnt_q == 16'(DIV - 1));

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick_q <= wrap;
    end
  end

  assign o_tick = tick_q;
endmodule
`default_nettype wire

// >>> hw/wdt_top.sv
// module: watchdog reset and interval timer
`timescale 1ns/1ps
`default_nettype none
module wdt_top
  import wdt_pkg::*;
#(
  parameter int OSC_DIV = WDT_OSC_DIV,
  parameter int GRACE = WDT_GRACE_TICKS,
  parameter int INTERVAL = WDT_INTERVAL_TICKS
)
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_POR,
  input wire logic [3:0] I_WATCHDOG_CONFIG_MODE,
  input wire logic I_LOW_POWER,
  input wire logic [7:0] I_WDATA,
  input wire logic I_TA_WE,
  input wire logic I_CTL_WE,
  input wire logic I_WATCHDOG_IRQ_ENABLE,
  input wire logic I_GLOBAL_IRQ_ENABLE,
  output logic [7:0] O_WATCHDOG_CONTROL_REG,
  output logic O_IRQ,
  output logic O_WAKE,
  output logic O_SYS_RESET
);
  // ----------------------------------------------------------------
  // input capture
  // ----------------------------------------------------------------
  wdt_wr_t wr;
  assign wr = '{data: I_WDATA, ta_we: I_TA_WE, ctl_we: I_CTL_WE};

  logic lp_s;
  wdt_sync u_lp_sync (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_d(I_LOW_POWER),
    .o_q(lp_s)
  );

  logic osc_tick;
  wdt_tick #(.DIV(OSC_DIV)) u_tick (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .o_tick(osc_tick)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [WDT_PRE_W-1:0] ps_mask(input logic [2:0] ps);
    logic [WDT_PRE_W-1:0] m;
    m = '0;
    unique case (ps)
      3'h0: m = 8'h00;
      3'h1: m = 8'h03;
      3'h2: m = 8'h07;
      3'h3: m = 8'h0f;
      3'h4: m = 8'h1f;
      3'h5: m = 8'h3f;
      3'h6: m = 8'h7f;
      3'h7: m = 8'hff;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_KEY1, ST_OPEN} wdt_ta_t;
  wdt_ta_t ta_q;
  wdt_ta_t ta_d;
  // fields sit in their own flops; cfg_q only bundles them for reading
  logic run_q;
  logic lpr_q;
  logic [2:0] ps_q;
  wdt_cfg_t cfg_q;
  logic tof_q;
  logic rcf_q;
  logic clr_q;
  logic [WDT_PRE_W-1:0] pre_q;
  logic [WDT_CNT_W-1:0] cnt_q;
  logic grace_q;
  logic [WDT_GRC_W-1:0] grc_q;
  logic lp_q;
  logic rst_q;
  logic irq_q;
  logic wake_q;

  assign cfg_q = '{run: run_q, lpr: lpr_q, ps: ps_q};

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire gp_mode = (I_WATCHDOG_CONFIG_MODE == WDT_CFG_GP);
  wire lp_stop = gp_mode ? !cfg_q.lpr
                         : (I_WATCHDOG_CONFIG_MODE == WDT_CFG_STOP_LP);
  // reset mode ignores run bit; general mode follows it
  wire running = (gp_mode ? cfg_q.run : 1'b1) &&
                 !(lp_s && lp_stop);
  wire lp_edge = lp_s ^ lp_q;
  wire ctl_ok = wr.ctl_we && (ta_q == ST_OPEN);
  wire clr_wr = ctl_ok && wr.data[WDT_BIT_CLR];
  wire pre_done = osc_tick && running && ((pre_q & ps_mask(cfg_q.ps)) ==
                  ps_mask(cfg_q.ps));
  wire timeout = pre_done && (cnt_q == WDT_CNT_W'(INTERVAL - 1));
  wire grc_done = grace_q && osc_tick &&
                  (grc_q == WDT_GRC_W'(GRACE - 1));
  wire wd_rst = grc_done && !gp_mode && !clr_wr;
  wire cnt_clr = clr_q || lp_edge;

  // ----------------------------------------------------------------
  // timed-access unlock sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    ta_d = ST_IDLE;
    unique case (ta_q)
      ST_IDLE: ta_d = (wr.ta_we && wr.data == WDT_TA_KEY1) ? ST_KEY1 : ST_IDLE;
      ST_KEY1:
      begin
        if (wr.ta_we)
          ta_d = (wr.data == WDT_TA_KEY2) ? ST_OPEN : ST_IDLE;
        else
          ta_d = ST_IDLE;
      end
      ST_OPEN: ta_d = (wr.ta_we && wr.data == WDT_TA_KEY1) ? ST_KEY1 : ST_IDLE;
      default: ta_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      ta_q <= ST_IDLE;
    else
      ta_q <= ta_d;
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST || I_POR)
    begin
      run_q <= 1'b0;
      lpr_q <= 1'b0;
      tof_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      if (ctl_ok && gp_mode)
      begin
        run_q <= wr.data[WDT_BIT_RUN];
        lpr_q <= wr.data[WDT_BIT_LPR];
      end
      // timeout set wins over a software clear
      if (timeout)
        tof_q <= 1'b1;
      else if (ctl_ok)
        tof_q <= wr.data[WDT_BIT_TOF];
      clr_q <= clr_wr;
    end
  end

  // prescale and cause flag survive non power-on resets
  always_ff @(posedge I_CLK)
  begin
    if (I_POR)
    begin
      ps_q <= WDT_PS_POR;
      rcf_q <= 1'b0;
    end
    else
    begin
      if (rst_q)
        rcf_q <= 1'b1;
      else if (ctl_ok && !I_SRST)
        rcf_q <= wr.data[WDT_BIT_RCF];
      if (ctl_ok && !I_SRST)
        ps_q <= wr.data[WDT_PS_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // counter, prescaler and grace window
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST || I_POR)
    begin
      pre_q <= '0;
      cnt_q <= '0;
      grace_q <= 1'b0;
      grc_q <= '0;
      lp_q <= 1'b0;
    end
    else
    begin
      lp_q <= lp_s;
      if (cnt_clr)
      begin
        pre_q <= '0;
        cnt_q <= '0;
      end
      else if (osc_tick && running)
      begin
        pre_q <= pre_done ? '0 : pre_q + 8'h01;
        // wrap at the interval end so every interval has the same length
        if (pre_done)
          cnt_q <= timeout ? '0 : cnt_q + 6'h01;
      end
      // one reset request per grace window; the next timeout re-arms it
      if (clr_wr || gp_mode || grc_done)
        grace_q <= 1'b0;
      else if (timeout)
        grace_q <= 1'b1;
      if (!grace_q || clr_wr)
        grc_q <= '0;
      else if (osc_tick)
        grc_q <= grc_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST || I_POR)
    begin
      rst_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      rst_q <= wd_rst;
      irq_q <= tof_q && I_WATCHDOG_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE;
      wake_q <= timeout && lp_s;
    end
  end

  assign O_WATCHDOG_CONTROL_REG = {cfg_q.run, clr_q, tof_q, cfg_q.lpr,
                                   rcf_q, cfg_q.ps};
  assign O_IRQ = irq_q;
  assign O_WAKE = wake_q;
  assign O_SYS_RESET = rst_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_TOF_SET: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    timeout |=> tof_q)
    else $error("timeout did not set flag");
  AST_IRQ: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    tof_q && I_WATCHDOG_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE |=> O_IRQ)
    else $error("irq not raised");
  AST_NO_LOCKED_WR: assert property (@(posedge I_CLK)
    disable iff (I_SRST || I_POR)
    wr.ctl_we && ta_q != ST_OPEN && !timeout && !rst_q |=>
    $stable(tof_q) && $stable(cfg_q.ps))
    else $error("write without unlock changed register");
  AST_CLR_SELF: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    clr_q && !clr_wr |=> !clr_q && cnt_q == '0)
    else $error("clear request not completed");
  AST_GP_HALT: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    gp_mode && !cfg_q.run && !cnt_clr |=> $stable(cnt_q))
    else $error("general timer counted while halted");
  AST_RST_CAUSE: assert property (@(posedge I_CLK) disable iff (I_POR)
    rst_q |=> rcf_q)
    else $error("reset cause flag not set");
  AST_GP_NO_RST: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    gp_mode |=> !O_SYS_RESET)
    else $error("general mode produced reset");
  AST_LP_CLR: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    lp_edge |=> cnt_q == '0 && pre_q == '0)
    else $error("low power change did not clear counter");
  AST_RST_GRACE: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    O_SYS_RESET |-> $past(grace_q, 2))
    else $error("reset without grace window");
  AST_CNT_WRAP: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    timeout |=> cnt_q == '0 && tof_q)
    else $error("counter did not restart after interval");
  AST_WAKE_LP: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    timeout && lp_s |=> O_WAKE)
    else $error("timeout in low power did not wake");
  AST_SRST_CLR: assert property (
    @(posedge I_CLK) disable iff (I_POR)
    I_SRST |=> cnt_q == '0 && pre_q == '0 && !tof_q)
    else $error("reset left counter running");
  AST_SRST_KEEP: assert property (
    @(posedge I_CLK) disable iff (I_POR)
    I_SRST && !rst_q |=> $stable(rcf_q) && $stable(cfg_q.ps))
    else $error("reset changed kept fields");
  AST_POR_PS: assert property (@(posedge I_CLK)
    I_POR |=> cfg_q.ps == WDT_PS_POR && !rcf_q)
    else $error("power-on did not set prescale");
  AST_TA_KEYS: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    ctl_ok |-> $past(wr.ta_we && wr.data == WDT_TA_KEY2) &&
    $past(wr.ta_we && wr.data == WDT_TA_KEY1, 2))
    else $error("control write accepted without unlock");
  AST_TA_CLOSE: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    ta_q == ST_OPEN && !wr.ta_we |=> ta_q == ST_IDLE)
    else $error("unlock stayed open");
  AST_RST_MODE_IGNORE: assert property (
    @(posedge I_CLK) disable iff (I_SRST || I_POR)
    !gp_mode && ctl_ok |=> $stable(cfg_q.run) && $stable(cfg_q.lpr))
    else $error("reset mode took run or low power bit");

  COV_TIMEOUT: cover property (@(posedge I_CLK) timeout);
  COV_RESET: cover property (@(posedge I_CLK) O_SYS_RESET);
  COV_UNLOCK: cover property (@(posedge I_CLK) ctl_ok);
  COV_WAKE: cover property (@(posedge I_CLK) O_WAKE);
endmodule
`default_nettype wire

// >>> verif/wdt_top_tb.sv
// testbench: timed-access writes and timer scenarios for the watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin check_count++; \
  if ((a) !== (b)) begin n_errors++; \
  $display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
module wdt_top_tb;
  import wdt_pkg::*;
  localparam int TB_TICK = 4;
  localparam int TB_INTERVAL = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic por = 1'b1;
  logic [3:0] cfg = 4'h0;
  logic lp = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic ta_we = 1'b0;
  logic ctl_we = 1'b0;
  logic ie = 1'b0;
  logic ge = 1'b0;
  logic [7:0] ctl;
  logic irq;
  logic wake;
  logic sys_rst;
  logic clr_seen;
  int n_errors = 0;
  int check_count = 0;
  int n_rst = 0;
  int n_wake = 0;

  // ----------------------------------------------------------------
  // clock, pulse counters and design
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;

  // one-cycle pulses are counted on the edge that shows them
  always @(posedge clk)
  begin
    if (sys_rst === 1'b1)
      n_rst++;
    if (wake === 1'b1)
      n_wake++;
  end

  wdt_top #(.OSC_DIV(TB_TICK), .GRACE(8), .INTERVAL(TB_INTERVAL)) dut_u (
    .I_CLK(clk),
    .I_SRST(srst),
    .I_POR(por),
    .I_WATCHDOG_CONFIG_MODE(cfg),
    .I_LOW_POWER(lp),
    .I_WDATA(wdata),
    .I_TA_WE(ta_we),
    .I_CTL_WE(ctl_we),
    .I_WATCHDOG_IRQ_ENABLE(ie),
    .I_GLOBAL_IRQ_ENABLE(ge),
    .O_WATCHDOG_CONTROL_REG(ctl),
    .O_IRQ(irq),
    .O_WAKE(wake),
    .O_SYS_RESET(sys_rst)
  );

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // gap set: an idle cycle between the two keys, which must abort
  task automatic wr_ctl(input logic [7:0] d, input bit gap);
    cyc(1);
    ta_we = 1'b1;
    wdata = WDT_TA_KEY1;
    cyc(1);
    ta_we = !gap;
    wdata = WDT_TA_KEY2;
    if (gap)
    begin
      cyc(1);
      ta_we = 1'b1;
    end
    cyc(1);
    ta_we = 1'b0;
    ctl_we = 1'b1;
    wdata = d;
    cyc(1);
    ctl_we = 1'b0;
    clr_seen = ctl[WDT_BIT_CLR];
    repeat (2)
    begin
      cyc(1);
      clr_seen = clr_seen | ctl[WDT_BIT_CLR];
    end
  endtask

  task automatic do_rst(input logic [3:0] c);
    cyc(1);
    srst = 1'b1;
    cfg = c;
    cyc(1);
    srst = 1'b0;
    cyc(1);
  endtask

  task automatic wait_bit(input int b, input logic v, input int max);
    int i;
    i = 0;
    while (i < max && ctl[b] !== v)
    begin
      cyc(1);
      i++;
    end
  endtask

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    int r0;
    int dv;
    repeat (8) @(posedge clk);
    #1;
    por = 1'b0;
    srst = 1'b0;
    cyc(1);
    `CHK(ctl, 8'h07)
    ctl_we = 1'b1;
    wdata = 8'h00;
    cyc(1);
    ctl_we = 1'b0;
    wr_ctl(8'h00, 1'b1);
    cyc(2);
    `CHK(ctl, 8'h07)
    // reset mode: run and low-power bits must not stick
    wr_ctl(8'h90, 1'b0);
    `CHK(ctl, 8'h00)
    ie = 1'b1;
    ge = 1'b1;
    wait_bit(WDT_BIT_TOF, 1'b1, 300);
    `CHK(ctl[WDT_BIT_TOF], 1'b1)
    cyc(2);
    `CHK(irq, 1'b1)
    `CHK(n_rst, 0)
    r0 = 0;
    while (n_rst == 0 && r0 < 300)
    begin
      cyc(1);
      r0++;
    end
    `CHK(n_rst, 1)
    cyc(2);
    `CHK(ctl[WDT_BIT_RCF], 1'b1)
    do_rst(4'h0);
    `CHK(ctl, 8'h08)
    cyc(2);
    `CHK(irq, 1'b0)
    // feeding inside the grace window holds the reset off
    wait_bit(WDT_BIT_TOF, 1'b1, 300);
    wr_ctl(8'h40, 1'b0);
    `CHK(clr_seen, 1'b1)
    `CHK(ctl, 8'h00)
    cyc(30);
    `CHK(n_rst, 1)
    do_rst(4'h5);
    lp = 1'b1;
    cyc(200);
    `CHK(ctl[WDT_BIT_TOF], 1'b0)
    `CHK(n_wake, 0)
    lp = 1'b0;
    do_rst(4'h0);
    lp = 1'b1;
    wait_bit(WDT_BIT_TOF, 1'b1, 300);
    `CHK(ctl[WDT_BIT_TOF], 1'b1)
    cyc(2);
    `CHK(n_wake > 0, 1'b1)
    lp = 1'b0;
    // general purpose mode
    do_rst(WDT_CFG_GP);
    r0 = n_rst;
    cyc(100);
    `CHK(ctl, 8'h00)
    wr_ctl(8'h90, 1'b0);
    `CHK(ctl, 8'h90)
    wait_bit(WDT_BIT_TOF, 1'b1, 300);
    `CHK(ctl[WDT_BIT_TOF], 1'b1)
    wr_ctl(8'hc1, 1'b0);
    cyc(40);
    `CHK(ctl[WDT_BIT_TOF], 1'b0)
    wait_bit(WDT_BIT_TOF, 1'b1, 200);
    `CHK(ctl[WDT_BIT_TOF], 1'b1)
    `CHK(n_rst, r0)
    wr_ctl(8'h00, 1'b0);
    cyc(150);
    `CHK(ctl, 8'h00)
    // remaining prescale codes, timed from the clear each write makes
    for (int k = 2; k < 8; k++)
    begin
      dv = 2 << k;
      wr_ctl(8'hc0 | 8'(k), 1'b0);
      `CHK(ctl[WDT_PS_MSB:0], 3'(k))
      cyc(TB_TICK * TB_INTERVAL * dv - 2 * TB_TICK);
      `CHK(ctl[WDT_BIT_TOF], 1'b0)
      wait_bit(WDT_BIT_TOF, 1'b1, 2 * TB_TICK);
      `CHK(ctl[WDT_BIT_TOF], 1'b1)
    end
    final_report;
  end

  initial
  begin
    #400000;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    final_report;
  end
endmodule
`default_nettype wire
